//--- design/discrete_io_consts.vh
// Address map, bit positions and reset values of the discrete I/O ports
`ifndef DISCRETE_IO_CONSTS_VH
`define DISCRETE_IO_CONSTS_VH

// Port addresses on the processor I/O space
`define IO_ADDR_W            12
`define ADDR_REMOTE_CAL      12'h321
`define ADDR_INTERNAL        12'h322
`define ADDR_SECOND_CTRL     12'h325

// Internal output port bits
`define BIT_PERIPH_RESET     6
`define BIT_CTRL_RESET_N     7

// Remote calibration input port bits
`define BIT_CAL_ENTER_N      0
`define BIT_CAL_SPAN_ZERO    1
`define BIT_CAL_RANGE        2
`define BIT_CAL_GAS          3

// Alarm relay port bits
`define BIT_HEALTH_OK        4
`define BIT_LIMIT_ONE        5
`define BIT_LIMIT_TWO        6
`define BIT_UPPER_RANGE      7

// Fixed read-back of the top two bits of each control input port
`define CTRL_IN_FIXED        2'h3

// Reset values of the output latches
`define RST_INTERNAL_OUT     8'h40
`define RST_SPARE_OUT        8'h00
`define RST_ALARM_OUT        8'h00
`define RD_UNMAPPED          8'h00

`endif

//--- design/pin_synchronizer.v
// Two-stage synchroniser bank for asynchronous input pins
`timescale 1ns/1ps

module pin_synchronizer #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Pins in, synchronised levels out
    input  wire [WIDTH-1:0] pin_async,
    output wire [WIDTH-1:0] pin_sync
);

    genvar i;

    // One chain per bit; the first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg sync_reg;

            // Reset to high: open contacts read as idle (pulled up)
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_reg <= 1'b1;
                    sync_reg <= 1'b1;
                end else begin
                    meta_reg <= pin_async[i];
                    sync_reg <= meta_reg;
                end
            end

            assign pin_sync[i] = sync_reg;
        end
    endgenerate

endmodule

//--- design/discrete_io_ports.v
// Byte-wide discrete I/O ports: internal, calibration and alarm relays
`timescale 1ns/1ps
`include "discrete_io_consts.vh"

// Notes on behaviour
// - Internal in and out share 0x322
// - Internal out bit 6 resets serial peripherals
// - Internal out bit 7 low resets controller
// - Cal port 0x321 bit 0 low enters calibration
// - Bit 1 span/zero, bit 2 range select
// - Bit 3 selects CO2 or O2 gas
// - Input bits 4-5 spare, 6-7 read one
// - Control output 0x321 holds eight spares
// - Port 0x325: spares 0-3, relays 4-7
// - Bit 4 high only when healthy
// - Bit 5 high above limit one
// - Bit 6 high above limit two
// - Bit 7 high while upper range active
// - Fieldbus mode: relays follow coil values
module discrete_io_ports #(
    parameter ADDR_W = `IO_ADDR_W
) (
    // Clock and reset
    input  wire              clk,
    input  wire              reset_n,
    // Processor I/O port
    input  wire [ADDR_W-1:0] io_addr,
    input  wire [7:0]        io_wr_data,
    input  wire              io_wr,
    input  wire              io_rd,
    output reg  [7:0]        io_rd_data,
    // Internal input pins
    input  wire [7:0]        internal_spare_in,
    // Remote calibration contact closures
    input  wire              remote_calibrate_enter_n,
    input  wire              remote_span_zero_select,
    input  wire              remote_range_select,
    input  wire              remote_gas_select,
    input  wire [1:0]        remote_spare_in,
    // Second control input pins
    input  wire [5:0]        second_spare_in,
    // Internal outputs
    output reg  [5:0]        internal_spare_out,
    output reg               serial_periph_reset,
    output reg               bus_controller_hw_reset_n,
    // Spare control outputs
    output reg  [7:0]        spare_control_out,
    output reg  [3:0]        alarm_port_spare_out,
    // Alarm relays
    output reg               health_ok_relay,
    output reg               level_limit_one_relay,
    output reg               level_limit_two_relay,
    output reg               upper_range_active_relay,
    // Fieldbus coil control, same clock domain
    input  wire              coil_mode,
    input  wire              coil_relay_a,
    input  wire              coil_relay_b,
    input  wire              coil_relay_c,
    input  wire              coil_relay_d,
    // Health qualifiers, same clock domain
    input  wire              alarm_any,
    input  wire              diagnostics_active,
    // Decoded calibration request
    output reg               cal_mode_active,
    output reg               cal_span_selected,
    output reg               cal_range_two_selected,
    output reg               cal_gas_co2_selected
);

    // Synchronised pin levels
    wire [7:0] internal_in_sync;
    wire [5:0] remote_in_sync;
    wire [5:0] second_in_sync;

    // Output latches written by the processor
    reg  [7:0] internal_out_reg;
    reg  [7:0] internal_out_next;
    reg  [7:0] spare_out_reg;
    reg  [7:0] spare_out_next;
    reg  [7:0] alarm_out_reg;
    reg  [7:0] alarm_out_next;

    // Read path
    reg  [7:0] rd_data_next;

    // Address decode strobes
    wire hit_remote;
    wire hit_internal;
    wire hit_second;

    // Write strobes, one per output latch
    wire wr_spare;
    wire wr_internal;
    wire wr_alarm;

    // Reset images, so each output flop resets to its latch's value
    localparam [7:0] INTERNAL_RST    = `RST_INTERNAL_OUT;
    localparam [7:0] SPARE_RST       = `RST_SPARE_OUT;
    localparam [7:0] ALARM_RST       = `RST_ALARM_OUT;

    // Spare fields sit below the first control bit of the internal and alarm ports
    localparam       INT_SPARE_MSB   = `BIT_PERIPH_RESET - 1;
    localparam       ALARM_SPARE_MSB = `BIT_HEALTH_OK - 1;

    // Assembled input port images
    wire [7:0] remote_cal_image;
    wire [7:0] second_ctrl_image;

    // Relay values before the output flops
    wire       health_block;
    reg        health_next;
    reg        limit_one_next;
    reg        limit_two_next;
    reg        upper_range_next;

    // Inverted calibration pins, active high
    wire [3:0] cal_req_next;

    // Contact closures are asynchronous to the processor clock
    pin_synchronizer #(
        .WIDTH       (8)
    ) u_sync_internal (
        .clk         (clk),
        .reset_n     (reset_n),
        .pin_async   (internal_spare_in),
        .pin_sync    (internal_in_sync)
    );

    pin_synchronizer #(
        .WIDTH       (6)
    ) u_sync_remote (
        .clk         (clk),
        .reset_n     (reset_n),
        .pin_async   ({remote_spare_in,
                       remote_gas_select,
                       remote_range_select,
                       remote_span_zero_select,
                       remote_calibrate_enter_n}),
        .pin_sync    (remote_in_sync)
    );

    pin_synchronizer #(
        .WIDTH       (6)
    ) u_sync_second (
        .clk         (clk),
        .reset_n     (reset_n),
        .pin_async   (second_spare_in),
        .pin_sync    (second_in_sync)
    );

    // Address decode; read and write share one address per port
    assign hit_remote   = (io_addr == `ADDR_REMOTE_CAL);
    assign hit_internal = (io_addr == `ADDR_INTERNAL);
    assign hit_second   = (io_addr == `ADDR_SECOND_CTRL);

    // Only one latch can match, so the strobes never overlap
    assign wr_spare    = io_wr & hit_remote;
    assign wr_internal = io_wr & hit_internal;
    assign wr_alarm    = io_wr & hit_second;

    // Top bits of the control input ports are tied high
    assign remote_cal_image  = {`CTRL_IN_FIXED, remote_in_sync};
    assign second_ctrl_image = {`CTRL_IN_FIXED, second_in_sync};

    // Outside coil mode, alarm or diagnostics forces the health relay to report a fault
    assign health_block = alarm_any | diagnostics_active;

    // Closed contact asks for the function; one inverter per pin
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_cal
            assign cal_req_next[k] = ~remote_in_sync[k];
        end
    endgenerate

    // Write latches: a byte stands until the next write to the port
    always @* begin
        internal_out_next = internal_out_reg;
        spare_out_next    = spare_out_reg;
        alarm_out_next    = alarm_out_reg;
        if (wr_internal) begin
            internal_out_next = io_wr_data;
        end else if (wr_spare) begin
            spare_out_next = io_wr_data;
        end else if (wr_alarm) begin
            alarm_out_next = io_wr_data;
        end
    end

    // Reset parks peripherals in reset until software releases them
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            internal_out_reg <= `RST_INTERNAL_OUT;
            spare_out_reg    <= `RST_SPARE_OUT;
            alarm_out_reg    <= `RST_ALARM_OUT;
        end else begin
            internal_out_reg <= internal_out_next;
            spare_out_reg    <= spare_out_next;
            alarm_out_reg    <= alarm_out_next;
        end
    end

    // Read mux; write-only latches are not visible, reads show pins
    always @* begin
        rd_data_next = `RD_UNMAPPED;
        if (hit_remote) begin
            rd_data_next = remote_cal_image;
        end else if (hit_internal) begin
            rd_data_next = internal_in_sync;
        end else if (hit_second) begin
            rd_data_next = second_ctrl_image;
        end else begin
            rd_data_next = `RD_UNMAPPED;
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_rd_data <= `RD_UNMAPPED;
        end else if (io_rd) begin
            io_rd_data <= rd_data_next;
        end else begin
            io_rd_data <= `RD_UNMAPPED;
        end
    end

    // Relay sources: processor byte or fieldbus coils
    always @* begin
        if (coil_mode) begin
            health_next      = coil_relay_a;
            limit_one_next   = coil_relay_b;
            limit_two_next   = coil_relay_c;
            upper_range_next = coil_relay_d;
        end else begin
            // Hardware also drops health on alarm or diagnostics
            health_next      = alarm_out_next[`BIT_HEALTH_OK] &
                               ~health_block;
            limit_one_next   = alarm_out_next[`BIT_LIMIT_ONE];
            limit_two_next   = alarm_out_next[`BIT_LIMIT_TWO];
            upper_range_next = alarm_out_next[`BIT_UPPER_RANGE];
        end
    end

    // Internal outputs; controller reset is active low on the pin
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            internal_spare_out        <= INTERNAL_RST[INT_SPARE_MSB:0];
            serial_periph_reset       <= INTERNAL_RST[`BIT_PERIPH_RESET];
            bus_controller_hw_reset_n <= INTERNAL_RST[`BIT_CTRL_RESET_N];
        end else begin
            internal_spare_out        <= internal_out_next[INT_SPARE_MSB:0];
            serial_periph_reset       <=
                internal_out_next[`BIT_PERIPH_RESET];
            bus_controller_hw_reset_n <=
                internal_out_next[`BIT_CTRL_RESET_N];
        end
    end

    // Spare control outputs at both control addresses
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spare_control_out    <= SPARE_RST;
            alarm_port_spare_out <= ALARM_RST[ALARM_SPARE_MSB:0];
        end else begin
            spare_control_out    <= spare_out_next;
            alarm_port_spare_out <=
                alarm_out_next[ALARM_SPARE_MSB:0];
        end
    end

    // Relays fail safe: health reads alarm until software says ok
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            health_ok_relay          <= ALARM_RST[`BIT_HEALTH_OK];
            level_limit_one_relay    <= ALARM_RST[`BIT_LIMIT_ONE];
            level_limit_two_relay    <= ALARM_RST[`BIT_LIMIT_TWO];
            upper_range_active_relay <= ALARM_RST[`BIT_UPPER_RANGE];
        end else begin
            health_ok_relay          <= health_next;
            level_limit_one_relay    <= limit_one_next;
            level_limit_two_relay    <= limit_two_next;
            upper_range_active_relay <= upper_range_next;
        end
    end

    // Decoded calibration request, active high for the firmware
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_mode_active        <= 1'b0;
            cal_span_selected      <= 1'b0;
            cal_range_two_selected <= 1'b0;
            cal_gas_co2_selected   <= 1'b0;
        end else begin
            cal_mode_active        <=
                cal_req_next[`BIT_CAL_ENTER_N];
            cal_span_selected      <=
                cal_req_next[`BIT_CAL_SPAN_ZERO];
            cal_range_two_selected <=
                cal_req_next[`BIT_CAL_RANGE];
            // Meaningful only on builds fitted with both sensors
            cal_gas_co2_selected   <=
                cal_req_next[`BIT_CAL_GAS];
        end
    end

endmodule

//--- tb/io_port_checker_asserts.sv
// Concurrent checks on the discrete I/O port pins
`timescale 1ns/1ps
`include "discrete_io_consts.vh"

module io_port_checker #(
    parameter ADDR_W = 12
) (
    // Clock, reset and processor port
    input wire              clk,
    input wire              reset_n,
    input wire [ADDR_W-1:0] io_addr,
    input wire [7:0]        io_wr_data,
    input wire              io_wr,
    input wire              io_rd,
    input wire [7:0]        io_rd_data,
    // Pins and outputs
    input wire              remote_calibrate_enter_n,
    input wire              serial_periph_reset,
    input wire              bus_controller_hw_reset_n,
    input wire [7:0]        spare_control_out,
    input wire              health_ok_relay,
    input wire              upper_range_active_relay,
    input wire              coil_mode,
    input wire              coil_relay_a,
    input wire              coil_relay_d,
    input wire              alarm_any,
    input wire              diagnostics_active,
    input wire              cal_mode_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Decoded strobes
    wire wr_int = io_wr && io_addr == `ADDR_INTERNAL;
    wire wr_cal = io_wr && io_addr == `ADDR_REMOTE_CAL;
    wire rd_in  = io_rd && (io_addr == `ADDR_REMOTE_CAL ||
                  io_addr == `ADDR_SECOND_CTRL);
    wire rd_map = rd_in || (io_rd && io_addr == `ADDR_INTERNAL);
    // Pin low long enough to pass both sync flops and the decode flop
    sequence s_enter_held;
        !remote_calibrate_enter_n [*4];
    endsequence
    a_periph_reset_wr: assert property (
        wr_int |=> serial_periph_reset == $past(io_wr_data[6]))
        else $error("peripheral reset bit not latched");
    a_ctrl_reset_wr: assert property (
        wr_int |=> bus_controller_hw_reset_n == $past(io_wr_data[7]))
        else $error("controller reset bit not latched");
    a_spare_out_wr: assert property (
        wr_cal |=> spare_control_out == $past(io_wr_data))
        else $error("spare control byte not latched");
    a_spare_out_hold: assert property (
        !wr_cal |=> $stable(spare_control_out))
        else $error("spare control byte changed without write");
    a_fixed_ones_rd: assert property (
        rd_in |=> io_rd_data[7:6] == 2'b11)
        else $error("control input top bits not one");
    a_idle_rd_zero: assert property (
        !rd_map |=> io_rd_data == 8'h00)
        else $error("read data not zero outside mapped read");
    a_health_gate: assert property (
        !coil_mode && (alarm_any || diagnostics_active) |=> !health_ok_relay)
        else $error("health relay high during alarm");
    a_coil_follow: assert property (
        coil_mode |=> health_ok_relay == $past(coil_relay_a) &&
        upper_range_active_relay == $past(coil_relay_d))
        else $error("relay not following coil");
    a_cal_enter: assert property (
        s_enter_held |-> cal_mode_active)
        else $error("calibration request not decoded");
endmodule

bind discrete_io_ports io_port_checker #(.ADDR_W(ADDR_W)) chk (
    .clk, .reset_n, .io_addr, .io_wr_data, .io_wr, .io_rd, .io_rd_data,
    .remote_calibrate_enter_n, .serial_periph_reset,
    .bus_controller_hw_reset_n, .spare_control_out, .health_ok_relay,
    .upper_range_active_relay, .coil_mode, .coil_relay_a, .coil_relay_d,
    .alarm_any, .diagnostics_active, .cal_mode_active
);

//--- tb/contact_panel.sv
// Contact closure panel model driving the device input pins
`timescale 1ns/1ps

module contact_panel (
    // Clock
    input  wire       clk,
    // Requested levels, 0 = contact closed
    input  wire [3:0] cal_req,
    input  wire [1:0] rsp_req,
    input  wire [7:0] int_req,
    input  wire [5:0] sec_req,
    // Pins into the device
    output reg  [7:0] internal_spare_in,
    output reg        remote_calibrate_enter_n,
    output reg        remote_span_zero_select,
    output reg        remote_range_select,
    output reg        remote_gas_select,
    output reg  [1:0] remote_spare_in,
    output reg  [5:0] second_spare_in
);
    // Contacts move just after an edge; the device synchronises them
    always @(posedge clk) begin
        remote_calibrate_enter_n <= cal_req[0];
        remote_span_zero_select  <= cal_req[1];
        remote_range_select      <= cal_req[2];
        remote_gas_select        <= cal_req[3];
        remote_spare_in          <= rsp_req;
        internal_spare_in        <= int_req;
        second_spare_in          <= sec_req;
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the discrete I/O ports
`timescale 1ns/1ps
`include "discrete_io_consts.vh"

module testbench;
    // Clock, reset and processor port
    reg         clk = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    reg  [11:0] io_addr = 12'h000;
    reg  [7:0]  io_wr_data = 8'h00, int_req = 8'h00, got;
    wire [7:0]  io_rd_data, internal_spare_in, spare_control_out;
    // Panel requests and pins
    reg  [3:0]  cal_req = 4'hf, coils = 4'h0;
    reg  [1:0]  rsp_req = 2'h3;
    reg  [5:0]  sec_req = 6'h00;
    wire        remote_calibrate_enter_n, remote_span_zero_select;
    wire        remote_range_select, remote_gas_select;
    wire [1:0]  remote_spare_in;
    wire [5:0]  second_spare_in, internal_spare_out;
    // Outputs and qualifiers
    wire        serial_periph_reset, bus_controller_hw_reset_n;
    wire [3:0]  alarm_port_spare_out, relays, cal;
    reg         coil_mode = 1'b0, alarm_any = 1'b0, diagnostics_active = 1'b0;
    integer     n_fail = 0, comparisons = 0, cycles = 0, i;

    discrete_io_ports dut (.clk, .reset_n, .io_addr, .io_wr_data, .io_wr,
        .io_rd, .io_rd_data, .internal_spare_in, .remote_calibrate_enter_n,
        .remote_span_zero_select, .remote_range_select, .remote_gas_select,
        .remote_spare_in, .second_spare_in, .internal_spare_out,
        .serial_periph_reset, .bus_controller_hw_reset_n, .spare_control_out,
        .alarm_port_spare_out, .health_ok_relay(relays[0]),
        .level_limit_one_relay(relays[1]), .level_limit_two_relay(relays[2]),
        .upper_range_active_relay(relays[3]), .coil_mode,
        .coil_relay_a(coils[0]), .coil_relay_b(coils[1]),
        .coil_relay_c(coils[2]), .coil_relay_d(coils[3]), .alarm_any,
        .diagnostics_active, .cal_mode_active(cal[0]),
        .cal_span_selected(cal[1]), .cal_range_two_selected(cal[2]),
        .cal_gas_co2_selected(cal[3]));
    contact_panel panel (.clk, .cal_req, .rsp_req, .int_req, .sec_req,
        .internal_spare_in, .remote_calibrate_enter_n,
        .remote_span_zero_select, .remote_range_select, .remote_gas_select,
        .remote_spare_in, .second_spare_in);

    always #2.5 clk = ~clk;
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk);
            io_addr <= a; io_wr_data <= d; io_wr <= 1'b1;
            @(posedge clk);
            io_wr <= 1'b0;
            #1;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge clk);
            io_addr <= a; io_rd <= 1'b1;
            @(posedge clk);
            io_rd <= 1'b0;
            #1 got = io_rd_data;
        end
    endtask
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1 check({bus_controller_hw_reset_n, serial_periph_reset,
            internal_spare_out}, `RST_INTERNAL_OUT);
        // Internal port: each reset control, then pins read back
        wr(`ADDR_INTERNAL, 8'h80);
        check({bus_controller_hw_reset_n, serial_periph_reset,
            internal_spare_out}, 8'h80);
        wr(`ADDR_INTERNAL, 8'h7f);
        check({bus_controller_hw_reset_n, serial_periph_reset,
            internal_spare_out}, 8'h7f);
        @(posedge clk) int_req <= 8'ha5;
        waitc(4);
        rd(`ADDR_INTERNAL);
        check(got, 8'ha5);
        $display("internal port test done");
        // Every closure pattern of the four calibration contacts
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk);
            cal_req <= i[3:0];
            rsp_req <= i[1:0];
            waitc(5);
            rd(`ADDR_REMOTE_CAL);
            check(got, {2'b11, i[1:0], i[3:0]});
            check({4'h0, cal}, {4'h0, ~i[3:0]});
        end
        @(posedge clk) sec_req <= 6'h2a;
        waitc(4);
        rd(`ADDR_SECOND_CTRL);
        check(got, 8'hea);
        $display("input port test done");
        // Spare outputs, reads stay on pins, unmapped accesses
        wr(`ADDR_REMOTE_CAL, 8'h5a);
        check(spare_control_out, 8'h5a);
        rd(`ADDR_REMOTE_CAL);
        check(got, 8'hff);
        wr(`ADDR_SECOND_CTRL, 8'hb5);
        wr(12'h324, 8'h00);
        check({relays, alarm_port_spare_out}, 8'hb5);
        check(spare_control_out, 8'h5a);
        rd(12'h323);
        check(got, 8'h00);
        // Health relay drops on alarm or diagnostics
        @(posedge clk) alarm_any <= 1'b1;
        waitc(2);
        check({7'h0, relays[0]}, 8'h00);
        @(posedge clk) {alarm_any, diagnostics_active} <= 2'b01;
        waitc(2);
        check({7'h0, relays[0]}, 8'h00);
        @(posedge clk) diagnostics_active <= 1'b0;
        waitc(2);
        check({7'h0, relays[0]}, 8'h01);
        wr(`ADDR_SECOND_CTRL, 8'h40);
        check({4'h0, relays}, 8'h04);
        wr(`ADDR_SECOND_CTRL, 8'ha0);
        check({4'h0, relays}, 8'h0a);
        $display("alarm relay test done");
        // Coil mode: relays follow coils regardless of alarm_any
        for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk);
            coil_mode <= 1'b1;
            coils <= i[3:0];
            alarm_any <= i[0];
            waitc(2);
            check({4'h0, relays}, {4'h0, i[3:0]});
        end
        @(posedge clk) coil_mode <= 1'b0;
        waitc(2);
        check({4'h0, relays}, 8'h0a);
        $display("coil mode test done");
        close_out;
    end
endmodule
